/* File: hw/srg_top.sv */
// Functional notes
// - role strap 0 selects slave with rate pin input, 1 master driving it.
// - rates from 10 SPS up to 1496 kSPS are supported.
// - slave emits one output word per external rate pulse.
// - slave rate change blanks words for changeover plus filter settling.
// - above 10 kSPS, slave changes under 500 SPS keep lock and data.
// - slave changeover is band lock time plus 512 output periods.
// - master divides the clock by a programmable ratio, from straps or registers.
// - pin master mode picks one of sixteen rates, also by filter type.
// - code 0000 gives 374/1496 kSPS, code 1111 gives 2.5/0.01 kSPS.
// - register ratio is 24-bit whole part plus 32-bit fraction.
// - new ratio takes effect only when the transfer bit is written.
// - master rate change blanks about 2 us plus filter settling.
// - in register control, each channel divides the rate by 1, 2, 4 or 8.
// - role and common straps are sampled once after reset release.
//
// Added by the designer: the address map and the APB slave port.
`include "srg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module srg_top #(
   parameter int unsigned CLK_HZ        = 10_000_000,
   parameter int unsigned LOCK_FAST_CYC = `SRG_LOCK_FAST_US * (CLK_HZ / 1_000_000),
   parameter int unsigned LOCK_SLOW_CYC = `SRG_LOCK_SLOW_MS * (CLK_HZ / 1000),
   parameter int unsigned SETTLE_WORDS  = 0,
   parameter int unsigned PER_W         = 21
) (
   input  wire logic              REF_CLK,
   input  wire logic              RST_N,
   input  wire logic              ROLE_STRAP,
   input  wire logic              CTRL_SPI_STRAP,
   input  wire logic              RATIO_STRAP0_DATACLK_DIR,
   input  wire logic              RATIO_STRAP1_DATACLK_GATING,
   input  wire logic              RATIO_STRAP2,
   input  wire logic              RATIO_STRAP3,
   input  wire srg_pkg::srg_filt_t FILTER_SEL,
   input  wire logic              RATE_PULSE_I,
   output logic                   RATE_PULSE_O,
   output logic                   RATE_PULSE_OE,
   output logic [3:0]             WORD_STROBE,
   output logic                   BLANKING,
   output logic                   DATA_CLK_DIR_OUT,
   output logic                   DATA_CLK_FREE,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic [31:0]            PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR
);
   import srg_pkg::*;

   localparam int unsigned TDELAY_CYC = (`SRG_TDELAY_NS * (CLK_HZ / 1000) + 999_999) / 1_000_000;
   localparam int unsigned P10K  = CLK_HZ / `SRG_FINE_MIN_SPS;
   localparam int unsigned P750K = CLK_HZ / 750_000;
   localparam int unsigned P374K = CLK_HZ / 374_000;
   localparam int unsigned P1460 = CLK_HZ / 1460;
   localparam int unsigned P732  = CLK_HZ / 732;
   localparam int unsigned P366  = CLK_HZ / 366;
   localparam int unsigned P183  = CLK_HZ / 183;
   localparam int unsigned P91   = CLK_HZ * 10 / 915;
   localparam int unsigned P45   = CLK_HZ * 10 / 457;
   localparam int unsigned P22   = CLK_HZ * 10 / 228;
   localparam int unsigned P11   = CLK_HZ * 10 / 114;

   // slowest rate must fit the period counter
   if (CLK_HZ / `SRG_ODR_MIN_SPS >= (64'd1 << PER_W) || CLK_HZ > 400_000_000) begin : g_chk
      $error("srg_top: CLK_HZ and PER_W cannot cover the rate range");
   end

   // fixed pin-mode rate table in SPS: wideband, sinc6, sinc3
   function automatic logic [20:0] pin_rate(input logic [3:0] c, input srg_filt_t f);
      logic [62:0] r;
      r = '0;
      case (c)
         4'h0: r = {21'd374000, 21'd1496000, 21'd1496000};
         4'h1: r = {21'd325000, 21'd1250000, 21'd1000000};
         4'h2: r = {21'd285000, 21'd1000000, 21'd750000};
         4'h3: r = {21'd256000, 21'd750000, 21'd375000};
         4'h4: r = {21'd235000, 21'd500000, 21'd187500};
         4'h5: r = {21'd200000, 21'd375000, 21'd128000};
         4'h6: r = {21'd175000, 21'd325000, 21'd64000};
         4'h7: r = {21'd128000, 21'd256000, 21'd32000};
         4'h8: r = {21'd100000, 21'd175000, 21'd16000};
         4'h9: r = {21'd80000, 21'd128000, 21'd5000};
         4'ha: r = {21'd64000, 21'd80000, 21'd2500};
         4'hb: r = {21'd32000, 21'd64000, 21'd1250};
         4'hc: r = {21'd16000, 21'd32000, 21'd625};
         4'hd: r = {21'd10000, 21'd10000, 21'd60};
         4'he: r = {21'd5000, 21'd5000, 21'd50};
         default: r = {21'd2500, 21'd2500, 21'd10};
      endcase
      case (f)
         SRG_FIR: return r[62:42];
         SRG_SINC6: return r[41:21];
         default: return r[20:0];
      endcase
   endfunction

   // lock band: bit 3 picks the slow base, low bits the doubling count
   function automatic logic [3:0] lock_band(input logic [PER_W-1:0] p, input logic s3);
      if (p <= P750K) return 4'h0;
      else if (p <= P374K) return 4'h1;
      else if (!s3 || p <= P1460) return 4'h2;
      else if (p <= P732) return 4'h3;
      else if (p <= P366) return 4'h4;
      else if (p <= P183) return 4'h8;
      else if (p <= P91) return 4'h9;
      else if (p <= P45) return 4'ha;
      else if (p <= P22) return 4'hb;
      else if (p <= P11) return 4'hc;
      else return 4'hd;
   endfunction

   logic [1:0]       rs_q;
   logic             rst_n;
   logic             strap_ok_q, master_q, spi_q, dir_q, free_q;
   logic [23:0]      whole_q;
   logic [31:0]      frac_q;
   logic [55:0]      act_q;
   logic [7:0]       chdiv_q;
   logic             wr, xfer_w, mchg, schg, chg, edge_s, evt, word;
   logic [5:0]       pin_q;
   logic [56:0]      acc_q, step, modv, sum;
   logic             mp_q, in_q, seen_q, valid_q, s3, big;
   logic [PER_W-1:0] cnt_q, per_q, dp;
   logic [3:0]       lb;
   logic [31:0]      ltgt, lcnt_q;
   logic [15:0]      scnt_q;
   srg_state_t       state_q;
   logic [7:0]       div_eff;

   // reset release through two flops
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) rs_q <= 2'h0;
      else rs_q <= {rs_q[0], 1'b1};
   end
   assign rst_n = rs_q[1];

   // straps caught once, first edge after release
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         strap_ok_q <= 1'b0;
         master_q   <= 1'b0;
         spi_q      <= 1'b0;
         dir_q      <= 1'b0;
         free_q     <= 1'b0;
      end else if (!strap_ok_q) begin
         strap_ok_q <= 1'b1;
         master_q   <= ROLE_STRAP;
         spi_q      <= CTRL_SPI_STRAP;
         dir_q      <= RATIO_STRAP0_DATACLK_DIR;
         free_q     <= RATIO_STRAP1_DATACLK_GATING;
      end
   end
   assign RATE_PULSE_OE    = master_q;
   assign DATA_CLK_DIR_OUT = dir_q;
   assign DATA_CLK_FREE    = free_q && !(master_q && !spi_q); // pin master: gated only

   // apb write side, zero wait states
   assign PREADY = 1'b1;
   assign wr     = PSEL && PENABLE && PWRITE;
   assign xfer_w = wr && PADDR == `SRG_OFF_CTRL && PWDATA[`SRG_CTRL_XFER];
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         whole_q <= `SRG_RST_WHOLE;
         frac_q  <= `SRG_RST_FRAC;
         act_q   <= {`SRG_RST_WHOLE, `SRG_RST_FRAC};
         chdiv_q <= `SRG_RST_CHDIV;
      end else begin
         if (wr && PADDR == `SRG_OFF_WHOLE) whole_q <= PWDATA[23:0];
         if (wr && PADDR == `SRG_OFF_FRAC) frac_q <= PWDATA;
         if (wr && PADDR == `SRG_OFF_CHDIV) chdiv_q <= PWDATA[7:0];
         if (xfer_w) act_q <= {whole_q, frac_q};
      end
   end

   // read data and error latched in setup phase
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         PRDATA  <= 32'h0;
         PSLVERR <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         PSLVERR <= 1'b0;
         case (PADDR)
            `SRG_OFF_CTRL: PRDATA <= 32'h0;
            `SRG_OFF_WHOLE: PRDATA <= {8'h0, whole_q};
            `SRG_OFF_FRAC: PRDATA <= frac_q;
            `SRG_OFF_CHDIV: PRDATA <= {24'h0, chdiv_q};
            `SRG_OFF_STAT: PRDATA <= {26'h0, state_q, valid_q, spi_q, master_q, BLANKING};
            `SRG_OFF_PERIOD: PRDATA <= 32'(per_q);
            default: begin
               PRDATA  <= 32'h0;
               PSLVERR <= 1'b1;
            end
         endcase
      end
   end

   // master rate change detect: pin code/filter or transfer bit
   assign mchg = strap_ok_q && master_q &&
                 (spi_q ? xfer_w : ({RATIO_STRAP3, RATIO_STRAP2, RATIO_STRAP1_DATACLK_GATING,
                                     RATIO_STRAP0_DATACLK_DIR, FILTER_SEL} != pin_q));
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) pin_q <= 6'h0;
      else pin_q <= {RATIO_STRAP3, RATIO_STRAP2, RATIO_STRAP1_DATACLK_GATING,
                     RATIO_STRAP0_DATACLK_DIR, FILTER_SEL};
   end

   // phase accumulator: step per clock against modulus
   assign step = spi_q ? (57'h1 << 32) : 57'(pin_rate({RATIO_STRAP3, RATIO_STRAP2,
                 RATIO_STRAP1_DATACLK_GATING, RATIO_STRAP0_DATACLK_DIR}, FILTER_SEL));
   assign modv = spi_q ? {1'b0, act_q} : 57'(CLK_HZ);
   assign sum  = acc_q + step;
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= 57'h0;
         mp_q  <= 1'b0;
      end else if (!master_q || mchg || modv == 57'h0) begin
         acc_q <= 57'h0;
         mp_q  <= 1'b0;
      end else if (modv <= step) begin // ratio of one or below: every clock
         acc_q <= 57'h0;
         mp_q  <= 1'b1;
      end else if (sum >= modv) begin
         acc_q <= sum - modv;
         mp_q  <= 1'b1;
      end else begin
         acc_q <= sum;
         mp_q  <= 1'b0;
      end
   end
   assign RATE_PULSE_O = mp_q && master_q;

   // slave pulse edge and period tracking
   assign edge_s = RATE_PULSE_I && !in_q && !master_q && strap_ok_q;
   assign dp     = cnt_q > per_q ? cnt_q - per_q : per_q - cnt_q;
   assign big    = dp > 1 && (per_q >= P10K ||
                   64'(dp) * 64'(CLK_HZ) >= 64'(`SRG_FINE_DELTA) * 64'(per_q) * 64'(per_q));
   assign schg   = edge_s && seen_q && (!valid_q || big);
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         in_q    <= 1'b0;
         cnt_q   <= '0;
         per_q   <= '0;
         seen_q  <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         in_q <= RATE_PULSE_I;
         if (edge_s) begin
            cnt_q  <= PER_W'(1);
            seen_q <= 1'b1;
            if (seen_q) begin
               per_q   <= cnt_q;
               valid_q <= 1'b1;
            end
         end else if (!(&cnt_q)) cnt_q <= cnt_q + PER_W'(1);
      end
   end

   // changeover length for the new slave rate
   assign s3   = FILTER_SEL == SRG_SINC3 || FILTER_SEL == SRG_SINC3_REJ;
   assign lb   = lock_band(cnt_q, s3);
   assign ltgt = lb[3] ? (LOCK_SLOW_CYC << lb[2:0]) : (LOCK_FAST_CYC << lb[2:0]);

   // blanking sequencer: lock wait, then settle words
   assign chg = mchg || schg;
   assign evt = master_q ? mp_q : edge_s;
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_RUN;
         lcnt_q  <= 32'h0;
         scnt_q  <= 16'h0;
      end else if (chg) begin
         state_q <= ST_LOCK;
         lcnt_q  <= master_q ? 32'(TDELAY_CYC - 1) : ltgt - 32'h1;
         scnt_q  <= master_q ? 16'(SETTLE_WORDS) : 16'(`SRG_SETTLE_PER + SETTLE_WORDS);
      end else begin
         case (state_q)
            ST_LOCK: begin
               if (lcnt_q == 32'h0) state_q <= scnt_q == 16'h0 ? ST_RUN : ST_SETTLE;
               else lcnt_q <= lcnt_q - 32'h1;
            end
            ST_SETTLE: begin
               if (evt) begin
                  if (scnt_q == 16'h1) state_q <= ST_RUN;
                  scnt_q <= scnt_q - 16'h1;
               end
            end
            default: state_q <= ST_RUN;
         endcase
      end
   end
   assign BLANKING = state_q != ST_RUN;
   assign word     = evt && !chg && state_q == ST_RUN && (master_q || valid_q);

   // per-channel rate dividers
   assign div_eff = spi_q ? chdiv_q : 8'h0;
   for (genvar ch = 0; ch < 4; ch++) begin : g_ch
      srg_div_t   sel;
      logic [2:0] dc_q;
      logic       ws_q;
      assign sel = div_eff[2*ch +: 2];
      always_ff @(posedge REF_CLK or negedge rst_n) begin
         if (!rst_n) begin
            dc_q <= 3'h0;
            ws_q <= 1'b0;
         end else begin
            ws_q <= word && dc_q == 3'h0;
            if (word) dc_q <= (dc_q + 3'h1) & ((3'h1 << sel) - 3'h1);
         end
      end
      assign WORD_STROBE[ch] = ws_q;
   end

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!rst_n);

   AST_ROLE_PIN: assert property ($rose(strap_ok_q) |-> RATE_PULSE_OE == $past(ROLE_STRAP))
      else $error("rate pin direction does not follow role strap");
   AST_STRAP_HOLD: assert property (strap_ok_q && $past(strap_ok_q) |-> $stable(master_q) && $stable(spi_q))
      else $error("strap state changed after capture");
   AST_SLAVE_WORD: assert property (word && !master_q && div_eff[1:0] == 2'h0 |=> WORD_STROBE[0])
      else $error("slave pulse gave no word on channel 0");
   AST_BLANK_QUIET: assert property (state_q != ST_RUN |=> WORD_STROBE == 4'h0)
      else $error("word emitted while blanking");
   AST_RATIO_HOLD: assert property (!xfer_w |=> $stable(act_q))
      else $error("active ratio changed without transfer");
   AST_MASTER_GAP: assert property (mchg |=> state_q == ST_LOCK && lcnt_q == 32'(TDELAY_CYC - 1))
      else $error("master changeover gap length wrong");
   AST_FAST_LOCK: assert property (schg && cnt_q <= P750K |=> lcnt_q == LOCK_FAST_CYC - 1)
      else $error("top band lock time wrong");
   AST_FINE_KEEP: assert property (edge_s && valid_q && dp <= 1 |=> state_q != ST_LOCK || $past(state_q) == ST_LOCK)
      else $error("jitter-sized change dropped lock");
   AST_DIV_TWO: assert property (master_q && spi_q && act_q == 56'h2_0000_0000 && mp_q && !mchg
      ##1 !mchg |-> !mp_q ##1 mp_q)
      else $error("ratio two does not pulse every other clock");
endmodule
`default_nettype wire

/* File: hw/srg_regs.svh */
`ifndef SRG_REGS_SVH
`define SRG_REGS_SVH
// register byte offsets
`define SRG_OFF_CTRL     8'h00
`define SRG_OFF_WHOLE    8'h04
`define SRG_OFF_FRAC     8'h08
`define SRG_OFF_CHDIV    8'h0c
`define SRG_OFF_STAT     8'h10
`define SRG_OFF_PERIOD   8'h14
// field positions and widths
`define SRG_CTRL_XFER    0
`define SRG_WHOLE_W      24
`define SRG_FRAC_W       32
// reset values
`define SRG_RST_WHOLE    24'h000040
`define SRG_RST_FRAC     32'h00000000
`define SRG_RST_CHDIV    8'h00
// timing and rate figures
`define SRG_TDELAY_NS    2000
`define SRG_LOCK_FAST_US 5500
`define SRG_LOCK_SLOW_MS 6000
`define SRG_SETTLE_PER   512
`define SRG_ODR_MIN_SPS  10
`define SRG_ODR_MAX_SPS  1496000
`define SRG_FINE_MIN_SPS 10000
`define SRG_FINE_DELTA   500
`endif

/* File: hw/srg_pkg.sv */
package srg_pkg;
   typedef enum logic [1:0] {SRG_FIR, SRG_SINC6, SRG_SINC3, SRG_SINC3_REJ} srg_filt_t;
   typedef enum logic [1:0] {ST_RUN, ST_LOCK, ST_SETTLE} srg_state_t;
   typedef logic [1:0] srg_div_t;
endpackage

/* File: dv/srg_pulse_src.sv */
`timescale 1ns/1ps
`default_nettype none
// host-side rate source driving the slave rate pin
module srg_pulse_src (
   input  wire logic        clk,
   input  wire logic        run,
   input  wire logic [15:0] period_cyc,
   output logic             pulse
);
   logic [15:0] cnt_q;
   // continuous one-cycle pulse train, line held low when stopped
   always_ff @(posedge clk) begin
      if (!run) begin
         cnt_q <= 16'h0001;
         pulse <= 1'b0;
      end else if (cnt_q >= period_cyc) begin
         cnt_q <= 16'h0001;
         pulse <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
         pulse <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: dv/sample_rate_generator_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "srg_regs.svh"
module sample_rate_generator_bench;
   import srg_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        role = 1'b1;
   logic        spi = 1'b1;
   logic [3:0]  code = 4'h0;
   srg_filt_t   filt = SRG_FIR;
   logic        run = 1'b0;
   logic [15:0] per = 16'h0028;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  pa = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic        pin, rpo, oe, blank, dir, free, prdy, perr, er;
   logic [3:0]  wso;
   logic [31:0] prd, rd;
   logic [7:0]  dv;
   int          error_cnt = 0;
   int          num_checks = 0;
   int          np, bl, n;
   int          ws[4];
   // wideband rates in tenths of kSPS, by ratio code
   int          tbl[16] = '{3740, 3250, 2850, 2560, 2350, 2000, 1750, 1280,
                            1000, 800, 640, 320, 160, 100, 50, 25};

   always #50 clk = ~clk;

   srg_top #(.LOCK_FAST_CYC(20), .LOCK_SLOW_CYC(40)) srg_top_i (
      .REF_CLK(clk), .RST_N(rst_n), .ROLE_STRAP(role), .CTRL_SPI_STRAP(spi),
      .RATIO_STRAP0_DATACLK_DIR(code[0]), .RATIO_STRAP1_DATACLK_GATING(code[1]),
      .RATIO_STRAP2(code[2]), .RATIO_STRAP3(code[3]), .FILTER_SEL(filt),
      .RATE_PULSE_I(pin), .RATE_PULSE_O(rpo), .RATE_PULSE_OE(oe), .WORD_STROBE(wso),
      .BLANKING(blank), .DATA_CLK_DIR_OUT(dir), .DATA_CLK_FREE(free), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
      .PREADY(prdy), .PSLVERR(perr));

   srg_pulse_src srg_pulse_src_i (.clk(clk), .run(run), .period_cyc(per), .pulse(pin));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %0h got %0h", nm, e, g);
      end
   endtask

   task automatic rng(input string nm, input int lo, input int hi, input int g);
      num_checks++;
      if (g < lo || g > hi) begin
         error_cnt++;
         $display("[FAIL] %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask

   // apb transfer: setup, then access held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (prdy !== 1'b1 && k < 20);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (k >= 20) begin
         error_cnt++;
         finish_test();
      end
   endtask

   task automatic reset_dut(input logic r, input logic s, input logic [3:0] c);
      @(posedge clk);
      rst_n <= 1'b0;
      run <= 1'b0;
      role <= r;
      spi <= s;
      code <= c;
      repeat (9) @(posedge clk);
      @(negedge clk);
      chk("oe_in_reset", 0, oe);
      chk("pready_in_reset", 1, prdy);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   // count pulses, blanking cycles and channel words over a window
   task automatic watch(input int cyc);
      np = 0;
      bl = 0;
      ws = '{0, 0, 0, 0};
      repeat (cyc) begin
         @(negedge clk);
         np += int'(rpo === 1'b1);
         bl += int'(blank === 1'b1);
         for (int i = 0; i < 4; i++) ws[i] += int'(wso[i] === 1'b1);
      end
   endtask

   task automatic setc(input logic [3:0] c, input srg_filt_t f);
      @(posedge clk);
      code <= c;
      filt <= f;
      watch(20);
      watch(2000);
   endtask

   initial begin
      void'($urandom(32'he5aa));
      reset_dut(1'b1, 1'b1, 4'h1);
      chk("oe_master", 1, oe);
      chk("dir_strap", 1, dir);
      role <= 1'b0;
      apb(1'b0, `SRG_OFF_WHOLE, 0);
      chk("whole_rst", 32'h40, rd);
      apb(1'b0, `SRG_OFF_FRAC, 0);
      chk("frac_rst", 0, rd);
      apb(1'b0, 8'h18, 0);
      chk("unmapped_err", 1, er);
      watch(640);
      rng("default_rate", 10, 10, np);
      chk("role_held", 1, oe);
      n = $urandom_range(12, 3);
      dv = 8'($urandom);
      apb(1'b1, `SRG_OFF_WHOLE, n);
      apb(1'b1, `SRG_OFF_CHDIV, {24'h0, dv});
      watch(320);
      rng("rate_before_xfer", 5, 5, np);
      apb(1'b1, `SRG_OFF_CTRL, 1);
      watch(40);
      rng("change_gap", 18, 22, bl);
      watch(n * 64);
      rng("new_rate", 64, 64, np);
      for (int i = 0; i < 4; i++) rng("chan_words", 64 >> dv[2*i+:2], 64 >> dv[2*i+:2], ws[i]);
      // ratio 2.5: whole 2, half of 2^32 as fraction
      apb(1'b1, `SRG_OFF_WHOLE, 2);
      apb(1'b1, `SRG_OFF_FRAC, 32'h80000000);
      apb(1'b1, `SRG_OFF_CTRL, 1);
      watch(40);
      watch(250);
      rng("frac_rate", 100, 100, np);
      $display("test master_register done");
      // pin control: every code with wideband, code 0 with sinc6 and sinc3
      reset_dut(1'b1, 1'b0, 4'h2);
      chk("free_pin_master", 0, free);
      for (int k = 0; k < 16; k++) begin
         setc(4'(k), SRG_FIR);
         rng("pin_rate", tbl[k] / 50 - 1, tbl[k] / 50 + 1, np);
      end
      setc(4'h0, SRG_SINC6);
      rng("pin_sinc6", 298, 300, np);
      setc(4'h0, SRG_SINC3);
      rng("pin_sinc3", 298, 300, np);
      $display("test master_pin done");
      reset_dut(1'b0, 1'b1, 4'h2);
      chk("oe_slave", 0, oe);
      chk("free_slave", 1, free);
      chk("dir_slave", 0, dir);
      // 250 kHz then 333 kHz, both in lock band 2
      @(posedge clk);
      run <= 1'b1;
      n = 0;
      while (wso[0] !== 1'b1 && n < 30000) begin
         @(negedge clk);
         n++;
      end
      rng("lock_wait", 0, 29999, n);
      watch(800);
      rng("slave_words", 20, 20, ws[0]);
      rng("slave_no_blank", 0, 0, bl);
      apb(1'b0, `SRG_OFF_PERIOD, 0);
      chk("slave_period", 40, rd);
      apb(1'b0, `SRG_OFF_STAT, 0);
      chk("slave_status", 32'hc, rd);
      @(posedge clk);
      per <= 16'h001e;
      watch(17000);
      rng("changeover", 15360, 16400, bl);
      rng("words_lost", (17000 - bl) / 30 - 2, (17000 - bl) / 30 + 1, ws[0]);
      watch(300);
      rng("resumed_words", 10, 10, ws[0]);
      $display("test slave done");
      finish_test();
   end
endmodule
`default_nettype wire
